/* File: dnc_pkg.sv */
/*
 * Constants and types shared by the DAC control block and its stored-image
 * memory. Assumes nothing of its surroundings.
 */
package dnc_pkg;

    // Widths of the stored image and the working register
    localparam int DNC_CODE_W = 12;
    localparam int DNC_IMG_W = 14;

    // Field positions inside the 14-bit image
    localparam int DNC_PD_HI_POS = 13;
    localparam int DNC_PD_LO_POS = 12;
    localparam int DNC_CODE_MSB_POS = 11;

    // As-shipped image: only the code msb set, giving mid-scale
    localparam logic [13:0] DNC_FACTORY_IMAGE = 14'h0800;

    // Power-down select encodings
    localparam logic [1:0] DNC_PD_NORMAL = 2'h0;
    localparam logic [1:0] DNC_PD_1K = 2'h1;
    localparam logic [1:0] DNC_PD_100K = 2'h2;
    localparam logic [1:0] DNC_PD_500K = 2'h3;

    // Command type encoding that also writes the stored image
    localparam logic [2:0] DNC_CMD_NVM_WRITE = 3'h3;

    // Default length of a stored-image write, in sys_clk cycles
    localparam int DNC_NVM_WRITE_CYCLES = 1000;

    // Control sequencer states
    typedef enum logic [1:0] {
        DNC_ST_OFF,
        DNC_ST_LOAD,
        DNC_ST_RUN,
        DNC_ST_WRITE
    } dnc_state_t;

endpackage : dnc_pkg

/* File: dnc_nvm_store.sv */
/*
 * Non-volatile image store of the DAC control block, one word wide.
 * Assumes writes come from the same clock; the read word is registered and
 * follows a write one cycle later.
 */
`timescale 1ns/10ps
module dnc_nvm_store
    import dnc_pkg::*;
#(
    parameter int WIDTH = DNC_IMG_W,
    parameter logic [WIDTH-1:0] INIT = DNC_FACTORY_IMAGE
)
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic wr_en,
    input wire logic [WIDTH-1:0] wr_data,
    output logic [WIDTH-1:0] rd_data_r
);

    logic [WIDTH-1:0] cell_r;

    // Storage cell; reset stands for the factory programming
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            cell_r <= INIT;
        else if (wr_en)
            cell_r <= wr_data;
    end

    // Registered read port
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            rd_data_r <= INIT;
        else
            rd_data_r <= cell_r;
    end

endmodule : dnc_nvm_store

/* File: dnc_ctrl.sv */
/*
 * Control logic of a 12-bit DAC with a 14-bit non-volatile settings image:
 * working register, reload on reset events, power-down decode, wake-up and
 * the stored-image write with its ready/busy flag.
 * Assumes a serial front end on sys_clk that delivers each complete write
 * command as a one-cycle cmd_valid pulse, and general call reset and wake-up
 * as one-cycle pulses. supply_ok comes from an analog comparator, unclocked.
 */
// How it works
// - Reset events copy stored image into working register
// - Power-on and general call reset both reload; logic ignores a general call reset during a write
// - Below supply threshold everything off, then reset
// - Two power-down bits select normal or power-down
// - 00 normal; 01/10/11 give 1k/100k/500k pull-down
// - Power-down stops conversion, command port stays live
// - Normal-mode write or wake-up leaves power-down; logic ignores a wake-up during a write
// - Stored image is 14 bits, readable and rewritable
// - Command type 011 starts stored-image write
// - Ready flag low during write, high after
// - Writes ignored while ready flag low
// - Code is unsigned binary, output ref*code/4096
// - Accesses accepted any time after power-on reset; logic takes commands only in run state, not in load or write
// - Shipped image gives mid-scale output
// - Type 00x updates working register only
// - Type 1xx commands are ignored
// - Factory image: code msb set, rest clear
// - Ready flag is reported for polling
`timescale 1ns/10ps
module dnc_ctrl
    import dnc_pkg::*;
#(
    parameter int NVM_WRITE_CYCLES = DNC_NVM_WRITE_CYCLES
)
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic supply_ok,
    input wire logic cmd_valid,
    input wire logic cmd_type_bit2,
    input wire logic cmd_type_bit1,
    input wire logic cmd_type_bit0,
    input wire logic cmd_powerdown_sel_hi,
    input wire logic cmd_powerdown_sel_lo,
    input wire logic [11:0] cmd_code,
    input wire logic gc_reset,
    input wire logic gc_wakeup,
    output logic [11:0] dac_code_r,
    output logic powerdown_sel_hi_r,
    output logic powerdown_sel_lo_r,
    output logic conv_enable_r,
    output logic load_1k_r,
    output logic load_100k_r,
    output logic load_500k_r,
    output logic nvm_write_done_flag_r,
    output logic [13:0] nvm_image_r
);

    localparam int CNT_W = $clog2(NVM_WRITE_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(NVM_WRITE_CYCLES - 1);

    // Output stage decode: {conversion on, 1k, 100k, 500k}
    function automatic logic [3:0] pd_decode(input logic [1:0] sel, input logic live);
        logic [3:0] res;
        res = 4'h0;
        if (live)
        begin
            case (sel)
                DNC_PD_NORMAL: res = 4'h8;
                DNC_PD_1K: res = 4'h4;
                DNC_PD_100K: res = 4'h2;
                DNC_PD_500K: res = 4'h1;
                default: res = 4'h0;
            endcase
        end
        return res;
    endfunction : pd_decode

    logic supply_meta_r;
    logic supply_sync_r;
    dnc_state_t state_r;
    dnc_state_t state_nxt;
    logic [CNT_W-1:0] wr_cnt_r;
    logic [11:0] code_nxt;
    logic [1:0] pd_nxt;
    logic [3:0] stage_nxt;
    logic [13:0] nvm_rd;
    logic [CNT_W-1:0] wr_seen_r;

    // Command decode
    wire logic [2:0] cmd_type = {cmd_type_bit2, cmd_type_bit1, cmd_type_bit0};
    wire logic cmd_take = (state_r == DNC_ST_RUN) && cmd_valid && !cmd_type_bit2;
    wire logic cmd_nvm = cmd_take && (cmd_type == DNC_CMD_NVM_WRITE);
    wire logic [13:0] cmd_image = {cmd_powerdown_sel_hi, cmd_powerdown_sel_lo, cmd_code};
    wire logic wr_end = (state_r == DNC_ST_WRITE) && (wr_cnt_r == CNT_LAST);

    // Supply comparator passes two flip-flops
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            supply_meta_r <= 1'b0;
            supply_sync_r <= 1'b0;
        end
        else
        begin
            supply_meta_r <= supply_ok;
            supply_sync_r <= supply_meta_r;
        end
    end

    // Sequencer and working register next values
    always_comb
    begin
        state_nxt = state_r;
        code_nxt = dac_code_r;
        pd_nxt = {powerdown_sel_hi_r, powerdown_sel_lo_r};
        case (state_r)
            DNC_ST_OFF:
                if (supply_sync_r)
                    state_nxt = DNC_ST_LOAD;
            DNC_ST_LOAD:
            begin
                code_nxt = nvm_rd[DNC_CODE_MSB_POS:0];
                pd_nxt = nvm_rd[DNC_PD_HI_POS:DNC_PD_LO_POS];
                state_nxt = DNC_ST_RUN;
            end
            DNC_ST_RUN:
                if (gc_reset)
                    state_nxt = DNC_ST_LOAD;
                else if (cmd_take)
                begin
                    code_nxt = cmd_code;
                    pd_nxt = cmd_image[DNC_PD_HI_POS:DNC_PD_LO_POS];
                    if (cmd_nvm)
                        state_nxt = DNC_ST_WRITE;
                end
                else if (gc_wakeup)
                    pd_nxt = DNC_PD_NORMAL;
            DNC_ST_WRITE:
                if (wr_end)
                    state_nxt = DNC_ST_RUN;
            default:
                state_nxt = DNC_ST_OFF;
        endcase
        if (!supply_sync_r)
            state_nxt = DNC_ST_OFF;
    end

    // Output stage follows the next power-down select in the same edge
    assign stage_nxt = pd_decode(pd_nxt, state_nxt != DNC_ST_OFF);

    // Sequencer state and write timer
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_r <= DNC_ST_OFF;
            wr_cnt_r <= '0;
        end
        else
        begin
            state_r <= state_nxt;
            wr_cnt_r <= (state_r == DNC_ST_WRITE) ? wr_cnt_r + 1'b1 : '0;
        end
    end

    // Working register, output stage and ready flag
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            dac_code_r <= '0;
            {powerdown_sel_hi_r, powerdown_sel_lo_r} <= DNC_PD_NORMAL;
            {conv_enable_r, load_1k_r, load_100k_r, load_500k_r} <= 4'h0;
            nvm_write_done_flag_r <= 1'b1;
        end
        else
        begin
            dac_code_r <= code_nxt;
            {powerdown_sel_hi_r, powerdown_sel_lo_r} <= pd_nxt;
            {conv_enable_r, load_1k_r, load_100k_r, load_500k_r} <= stage_nxt;
            nvm_write_done_flag_r <= (state_nxt != DNC_ST_WRITE);
        end
    end

    // Stored image, reset to the as-shipped mid-scale value
    dnc_nvm_store #(
        .WIDTH(DNC_IMG_W),
        .INIT(DNC_FACTORY_IMAGE)
    ) dnc_nvm_store_i (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .wr_en(cmd_nvm),
        .wr_data(cmd_image),
        .rd_data_r(nvm_rd)
    );

    // Image readback port
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            nvm_image_r <= DNC_FACTORY_IMAGE;
        else
            nvm_image_r <= nvm_rd;
    end

    AST_RELOAD: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (state_r == DNC_ST_LOAD) && supply_sync_r |=> (dac_code_r == $past(nvm_rd[11:0]))
        && ({powerdown_sel_hi_r, powerdown_sel_lo_r} == $past(nvm_rd[13:12])))
        else $error("Working register not reloaded from image");

    AST_GC_RESET: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (state_r == DNC_ST_RUN) && gc_reset && supply_sync_r |=> (state_r == DNC_ST_LOAD)
        ##1 (state_r == DNC_ST_RUN) || !supply_sync_r)
        else $error("General call reset did not reload");

    AST_SUPPLY_OFF: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !supply_sync_r |=> (state_r == DNC_ST_OFF) && !conv_enable_r && !load_1k_r
        && !load_100k_r && !load_500k_r)
        else $error("Circuits active below supply threshold");

    AST_STAGE_DECODE: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (state_r != DNC_ST_OFF) |-> (conv_enable_r == ({powerdown_sel_hi_r, powerdown_sel_lo_r} == 2'h0))
        && (load_1k_r == ({powerdown_sel_hi_r, powerdown_sel_lo_r} == 2'h1))
        && (load_100k_r == ({powerdown_sel_hi_r, powerdown_sel_lo_r} == 2'h2))
        && (load_500k_r == ({powerdown_sel_hi_r, powerdown_sel_lo_r} == 2'h3)))
        else $error("Output stage does not match power-down select");

    AST_WAKE: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (state_r == DNC_ST_RUN) && supply_sync_r && !gc_reset
        && ((gc_wakeup && !cmd_take)
        || (cmd_take && !cmd_powerdown_sel_hi && !cmd_powerdown_sel_lo))
        |=> conv_enable_r)
        else $error("Did not leave power-down at once");

    AST_WRITE_BUSY: assert property (@(posedge sys_clk) disable iff (sys_rst)
        cmd_nvm && !gc_reset && supply_sync_r |=> !nvm_write_done_flag_r [*8])
        else $error("Ready flag not low during image write");

    // Separate count of cycles spent writing, so the length check does not lean on wr_cnt_r
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            wr_seen_r <= '0;
        else if (state_r == DNC_ST_WRITE)
            wr_seen_r <= wr_seen_r + 1'b1;
        else
            wr_seen_r <= '0;
    end

    AST_WRITE_LEN: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $fell(state_r == DNC_ST_WRITE) && (state_r == DNC_ST_RUN)
        |-> (wr_seen_r == NVM_WRITE_CYCLES))
        else $error("Image write length wrong");

    AST_WRITE_BOUND: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (state_r == DNC_ST_WRITE) |-> (wr_seen_r < NVM_WRITE_CYCLES))
        else $error("Image write runs too long");

    AST_BUSY_IGNORE: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (state_r == DNC_ST_WRITE) && supply_sync_r |=> $stable(dac_code_r)
        && $stable(powerdown_sel_hi_r) && $stable(powerdown_sel_lo_r))
        else $error("Write accepted while busy");

    AST_RESERVED: assert property (@(posedge sys_clk) disable iff (sys_rst)
        cmd_valid && cmd_type_bit2 && !gc_reset && !gc_wakeup && supply_sync_r
        && (state_r == DNC_ST_RUN) |=> $stable(dac_code_r) && $stable(nvm_rd))
        else $error("Reserved command had an effect");

    AST_FAST_NO_NVM: assert property (@(posedge sys_clk) disable iff (sys_rst)
        cmd_take && !cmd_type_bit1 |=> ##1 $stable(nvm_rd))
        else $error("Fast write touched the image");

endmodule : dnc_ctrl

/* File: dnc_host_model.sv */
/*
 * Command source that stands in for the serial front end and the bus master.
 * Assumes the bench raises send, s_gcr or s_gcw for one sys_clk cycle per request.
 */
`timescale 1ns/10ps
module dnc_host_model
(
    input wire logic sys_clk,
    input wire logic send,
    input wire logic [2:0] s_type,
    input wire logic [13:0] s_img,
    input wire logic s_gcr,
    input wire logic s_gcw,
    output logic cmd_valid,
    output logic [2:0] cmd_type,
    output logic [13:0] cmd_img,
    output logic gc_reset,
    output logic gc_wakeup
);
    // Idle values at time zero
    initial
    begin
        cmd_valid = 1'b0;
        gc_reset = 1'b0;
        gc_wakeup = 1'b0;
        cmd_type = 3'h0;
        cmd_img = 14'h0000;
    end

    // One-cycle pulses; fields toggle when no command is sent, so nothing stale is trusted
    always @(posedge sys_clk)
    begin
        cmd_valid <= send;
        gc_reset <= s_gcr;
        gc_wakeup <= s_gcw;
        cmd_type <= send ? s_type : ~cmd_type;
        cmd_img <= send ? s_img : ~cmd_img;
    end
endmodule : dnc_host_model

/* File: dac_nvm_powerdown_control_tb.sv */
/*
 * Self-checking bench for the DAC control block, commands sent through the host model.
 * Assumes the shortened stored-image write of 8 cycles.
 */
`timescale 1ns/10ps
module dac_nvm_powerdown_control_tb
    import dnc_pkg::*;
;
    localparam int NWC = 8;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic supply_ok = 1'b1;
    logic send = 1'b0;
    logic [2:0] s_type = 3'h0;
    logic [13:0] s_img = 14'h0000;
    logic s_gcr = 1'b0;
    logic s_gcw = 1'b0;
    wire logic cmd_valid, gc_reset, gc_wakeup;
    wire logic [2:0] cmd_type;
    wire logic [13:0] cmd_img;
    logic [11:0] dac_code_r;
    logic pd_hi, pd_lo, conv, l1k, l100k, l500k, flag;
    logic [13:0] nvm_image_r;
    logic [13:0] w;
    int mismatches = 0;
    int checked = 0;
    int k;

    // Clock of 50 ns
    always #25 sys_clk = ~sys_clk;

    dnc_host_model dnc_host_model_i (.sys_clk(sys_clk), .send(send), .s_type(s_type),
        .s_img(s_img), .s_gcr(s_gcr), .s_gcw(s_gcw), .cmd_valid(cmd_valid),
        .cmd_type(cmd_type), .cmd_img(cmd_img), .gc_reset(gc_reset), .gc_wakeup(gc_wakeup));

    dnc_ctrl #(.NVM_WRITE_CYCLES(NWC)) dnc_ctrl_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .supply_ok(supply_ok), .cmd_valid(cmd_valid), .cmd_type_bit2(cmd_type[2]),
        .cmd_type_bit1(cmd_type[1]), .cmd_type_bit0(cmd_type[0]),
        .cmd_powerdown_sel_hi(cmd_img[13]), .cmd_powerdown_sel_lo(cmd_img[12]),
        .cmd_code(cmd_img[11:0]), .gc_reset(gc_reset), .gc_wakeup(gc_wakeup),
        .dac_code_r(dac_code_r), .powerdown_sel_hi_r(pd_hi), .powerdown_sel_lo_r(pd_lo),
        .conv_enable_r(conv), .load_1k_r(l1k), .load_100k_r(l100k), .load_500k_r(l500k),
        .nvm_write_done_flag_r(flag), .nvm_image_r(nvm_image_r));

    // Single value comparison
    task automatic compare(input logic [13:0] got, input logic [13:0] exp);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : compare

    // Working register, output stage and ready flag against expectation
    task automatic check_out(input logic [13:0] img, input logic rdy, input logic on);
        logic [3:0] stage;
        stage = on ? (4'h8 >> img[13:12]) : 4'h0;
        compare({pd_hi, pd_lo, dac_code_r}, img);
        compare({10'h000, conv, l1k, l100k, l500k}, {10'h000, stage});
        compare({13'h0000, flag}, {13'h0000, rdy});
    endtask : check_out

    // Let n edges pass, then sample settled outputs
    task automatic cycles(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : cycles

    // One request through the host model; returns just after the accepting edge
    task automatic issue(input logic [2:0] t, input logic [13:0] img, input logic gr,
        input logic gw);
        @(posedge sys_clk);
        send <= !(gr || gw);
        s_type <= t;
        s_img <= img;
        s_gcr <= gr;
        s_gcw <= gw;
        @(posedge sys_clk);
        send <= 1'b0;
        s_gcr <= 1'b0;
        s_gcw <= 1'b0;
        cycles(1);
    endtask : issue

    // Counts and verdict
    task automatic end_sim;
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_sim

    // Test sequence
    initial
    begin
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        cycles(6);
        check_out(DNC_FACTORY_IMAGE, 1'b1, 1'b1);
        compare(nvm_image_r, 14'h0800);
        for (k = 0; k < 4; k++)
        begin
            w = {2'(k), 12'h0f0 + 12'(k)};
            issue((k == 3) ? 3'h2 : 3'(k), w, 1'b0, 1'b0);
            check_out(w, 1'b1, 1'b1);
            compare(nvm_image_r, 14'h0800);
        end
        for (k = 4; k < 8; k++)
        begin
            issue(3'(k), 14'h1555, 1'b0, 1'b0);
            check_out(w, 1'b1, 1'b1);
        end
        issue(3'h0, 14'h0000, 1'b0, 1'b1);
        check_out({2'b00, w[11:0]}, 1'b1, 1'b1);
        issue(3'h0, 14'h1321, 1'b0, 1'b0);
        check_out(14'h1321, 1'b1, 1'b1);
        issue(3'h2, 14'h0fff, 1'b0, 1'b0);
        check_out(14'h0fff, 1'b1, 1'b1);
        w = 14'h2abc;
        issue(DNC_CMD_NVM_WRITE, w, 1'b0, 1'b0);
        check_out(w, 1'b0, 1'b1);
        issue(3'h0, 14'h0123, 1'b0, 1'b0);
        check_out(w, 1'b0, 1'b1);
        k = 0;
        while (flag !== 1'b1 && k < 40)
        begin
            cycles(1);
            k++;
        end
        // Flag is low for NWC edges from acceptance; the refused request used three of them
        compare(14'(k), 14'(NWC - 3));
        check_out(w, 1'b1, 1'b1);
        compare(nvm_image_r, w);
        issue(3'h0, 14'h0555, 1'b0, 1'b0);
        issue(3'h0, 14'h0000, 1'b1, 1'b0);
        cycles(2);
        check_out(w, 1'b1, 1'b1);
        issue(3'h1, 14'h0555, 1'b0, 1'b0);
        @(posedge sys_clk);
        supply_ok <= 1'b0;
        cycles(4);
        check_out(14'h0555, 1'b1, 1'b0);
        @(posedge sys_clk);
        supply_ok <= 1'b1;
        cycles(6);
        check_out(w, 1'b1, 1'b1);
        end_sim();
    end

    // Watchdog against a hang
    initial
    begin
        repeat (2000) @(posedge sys_clk);
        mismatches++;
        end_sim();
    end
endmodule : dac_nvm_powerdown_control_tb
